// ==== hw/wkd_pkg.sv ====
package wkd_pkg;

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    localparam int WKD_NUM_PINS = 3;
    localparam int WKD_NUM_ALT = 2;
    localparam int WKD_NUM_CHAN = WKD_NUM_PINS + WKD_NUM_ALT;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int WKD_CLK_PERIOD_NS = 100;
    localparam int WKD_FILT_SHORT_NS = 16000;
    localparam int WKD_FILT_LONG_NS = 64000;
    localparam int WKD_FILT_SHORT_CYC =
        (WKD_FILT_SHORT_NS + WKD_CLK_PERIOD_NS - 1) / WKD_CLK_PERIOD_NS;
    localparam int WKD_FILT_LONG_CYC =
        (WKD_FILT_LONG_NS + WKD_CLK_PERIOD_NS - 1) / WKD_CLK_PERIOD_NS;
    localparam int WKD_CNT_W = 10;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int WKD_ADDR_W = 8;
    localparam logic [7:0] WKD_OFS_ENABLE = 8'h00;
    localparam logic [7:0] WKD_OFS_PULL = 8'h04;
    localparam logic [7:0] WKD_OFS_FILTER = 8'h08;
    localparam logic [7:0] WKD_OFS_SRC = 8'h0C;
    localparam logic [7:0] WKD_OFS_ALT_SRC = 8'h10;
    localparam logic [7:0] WKD_OFS_LEVEL = 8'h14;
    localparam logic [7:0] WKD_OFS_MASK = 8'h18;
    localparam logic [7:0] WKD_OFS_ALT_EN = 8'h1C;

    // Field positions
    localparam int WKD_SRC_LSB = 0;
    localparam int WKD_ALT_LSB = 3;

    // Reset values
    localparam logic [2:0] WKD_RST_ENABLE = 3'h0;
    localparam logic [5:0] WKD_RST_PULL = 6'h00;
    localparam logic [5:0] WKD_RST_FILTER = 6'h00;
    localparam logic [4:0] WKD_RST_MASK = 5'h00;
    localparam logic [1:0] WKD_RST_ALT_EN = 2'h0;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WKD_PULL_NONE = 2'b00,
        WKD_PULL_DOWN = 2'b01,
        WKD_PULL_UP = 2'b10,
        WKD_PULL_AUTO = 2'b11
    } wkd_pull_t;

    typedef enum logic [1:0] {
        WKD_FLT_STATIC_SHORT = 2'b00,
        WKD_FLT_STATIC_LONG = 2'b01,
        WKD_FLT_CYCLIC_A = 2'b10,
        WKD_FLT_CYCLIC_B = 2'b11
    } wkd_filter_t;

    typedef enum logic [1:0] {
        WKD_MODE_NORMAL = 2'b00,
        WKD_MODE_STOP = 2'b01,
        WKD_MODE_SLEEP = 2'b10,
        WKD_MODE_FAILSAFE = 2'b11
    } wkd_power_t;

    typedef struct packed {
        logic [WKD_ADDR_W-1:0] addr;
        logic write;
        logic [31:0] wdata;
    } wkd_apb_req_t;

endpackage

// ==== hw/wkd_filter.sv ====
`timescale 1ns/100ps
module wkd_filter
    import wkd_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic pin_in,
    input wire logic long_filter_in,
    input wire logic active_in,
    output logic event_out,
    output logic level_out
);

    logic [WKD_CNT_W-1:0] cnt;
    logic [WKD_CNT_W-1:0] limit;
    logic differs;
    logic done;

    assign limit = long_filter_in ? WKD_CNT_W'(WKD_FILT_LONG_CYC - 1)
                                  : WKD_CNT_W'(WKD_FILT_SHORT_CYC - 1);
    assign differs = pin_in != level_out;
    assign done = differs && (cnt == limit);

    // Crossing back before expiry restarts the interval
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cnt <= '0;
            level_out <= 1'b0;
            event_out <= 1'b0;
        end
        else
        begin
            event_out <= active_in && done; // see [R1]
            if (!active_in || !differs)
                cnt <= '0; // see [R4]
            else if (done)
            begin
                cnt <= '0;
                level_out <= pin_in; // see [R4]
            end
            else
                cnt <= cnt + 1'b1;
        end
    end

    a_filter_span: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        $rose(event_out) |-> $past(active_in) && $past(differs)) // see [R4]
        else $error("Edge accepted without a pending crossing");

endmodule // wkd_filter

// ==== hw/wkd_wake_input.sv ====
`timescale 1ns/100ps
// Behaviour
// [R1] Both pin edges produce a wake signal
// [R2] Interrupt in normal/stop, wake in sleep/fail-safe
// [R3] Static always active, cyclic only in window
// [R4] Accept edge only if stable for filter
// [R5] Per-pin wake enable in control register
// [R6] Sticky per-pin wake source bit, readable
// [R7] Levels readable in normal/stop, cyclic sampled
// [R8] Fail-output wakes: short filter, separate status
// [R9] Pull field: none, down, up, auto
// [R10] Auto pull follows detected pin level
// [R11] Filter field: short, long, cyclic A/B
// [R12] Host pairs cyclic timer with high-side output
// [R13] Three independent wake channels
module wkd_wake_input
    import wkd_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic apb_psel_in,
    input wire logic apb_penable_in,
    input wire logic apb_pwrite_in,
    input wire logic [WKD_ADDR_W-1:0] apb_paddr_in,
    input wire logic [31:0] apb_pwdata_in,
    output logic apb_pready_out,
    output logic [31:0] apb_prdata_out,
    output logic apb_pslverr_out,
    input wire logic [WKD_NUM_PINS-1:0] wake_pin_in,
    input wire logic [WKD_NUM_ALT-1:0] fail_output_pins_in,
    input wire logic cyclic_timer_a_window_in,
    input wire logic cyclic_timer_b_window_in,
    input wire logic [1:0] power_mode_in,
    output logic [WKD_NUM_PINS-1:0] pull_up_out,
    output logic [WKD_NUM_PINS-1:0] pull_down_out,
    output logic irq_out,
    output logic wake_request_out
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [WKD_NUM_PINS-1:0] wake_enable_control;
    logic [2*WKD_NUM_PINS-1:0] wake_pull_control;
    logic [2*WKD_NUM_PINS-1:0] wake_filter_control;
    logic [WKD_NUM_PINS-1:0] wake_source_status;
    logic [WKD_NUM_ALT-1:0] alt_wake_source_status;
    logic [WKD_NUM_ALT-1:0] alt_wake_enable;
    logic [WKD_NUM_CHAN-1:0] irq_mask;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wkd_apb_req_t req;
    logic setup_phase;
    logic wr_commit;
    logic hit_enable;
    logic hit_pull;
    logic hit_filter;
    logic hit_src;
    logic hit_alt_src;
    logic hit_level;
    logic hit_mask;
    logic hit_alt_en;
    logic hit_any;
    logic [31:0] next_rdata;

    assign req = '{addr: apb_paddr_in, write: apb_pwrite_in,
                   wdata: apb_pwdata_in};
    assign setup_phase = apb_psel_in && !apb_penable_in;
    assign wr_commit = apb_psel_in && apb_penable_in && apb_pready_out
                       && req.write;
    assign hit_enable = req.addr == WKD_OFS_ENABLE;
    assign hit_pull = req.addr == WKD_OFS_PULL;
    assign hit_filter = req.addr == WKD_OFS_FILTER;
    assign hit_src = req.addr == WKD_OFS_SRC;
    assign hit_alt_src = req.addr == WKD_OFS_ALT_SRC;
    assign hit_level = req.addr == WKD_OFS_LEVEL;
    assign hit_mask = req.addr == WKD_OFS_MASK;
    assign hit_alt_en = req.addr == WKD_OFS_ALT_EN;
    assign hit_any = hit_enable || hit_pull || hit_filter || hit_src
                     || hit_alt_src || hit_level || hit_mask || hit_alt_en;

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    logic [WKD_NUM_CHAN-1:0] chan_pin;
    logic [WKD_NUM_CHAN-1:0] chan_long;
    logic [WKD_NUM_CHAN-1:0] chan_active;
    logic [WKD_NUM_CHAN-1:0] chan_event;
    logic [WKD_NUM_CHAN-1:0] chan_level;
    logic irq_mode;

    assign irq_mode = power_mode_in == WKD_MODE_NORMAL
                      || power_mode_in == WKD_MODE_STOP;
    assign chan_pin = {fail_output_pins_in, wake_pin_in};

    genvar g;
    generate
        for (g = 0; g < WKD_NUM_PINS; g++)
        begin : g_pin
            wkd_filter_t flt;
            assign flt = wkd_filter_t'(wake_filter_control[2*g +: 2]);
            assign chan_long[g] = flt == WKD_FLT_STATIC_LONG; // see [R11]
            // Cyclic pins listen only inside their timer window
            assign chan_active[g] =
                (flt == WKD_FLT_CYCLIC_A) ? cyclic_timer_a_window_in :
                (flt == WKD_FLT_CYCLIC_B) ? cyclic_timer_b_window_in :
                1'b1; // see [R3]
        end
        for (g = WKD_NUM_PINS; g < WKD_NUM_CHAN; g++)
        begin : g_alt
            assign chan_long[g] = 1'b0; // see [R8]
            assign chan_active[g] = alt_wake_enable[g-WKD_NUM_PINS];
        end
        for (g = 0; g < WKD_NUM_CHAN; g++)
        begin : g_chan
            wkd_filter u_filter ( // see [R13]
                .ref_clk_in(ref_clk_in),
                .rst_in(rst_in),
                .pin_in(chan_pin[g]),
                .long_filter_in(chan_long[g]),
                .active_in(chan_active[g]),
                .event_out(chan_event[g]),
                .level_out(chan_level[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Status and events
    // ------------------------------------------------------------
    logic [WKD_NUM_PINS-1:0] src_set;
    logic [WKD_NUM_ALT-1:0] alt_set;
    logic [WKD_NUM_PINS-1:0] src_clr;
    logic [WKD_NUM_ALT-1:0] alt_clr;
    logic [WKD_NUM_PINS-1:0] next_src;
    logic [WKD_NUM_ALT-1:0] next_alt;
    logic [WKD_NUM_CHAN-1:0] next_status;
    logic any_wake_event;

    assign src_set = chan_event[WKD_NUM_PINS-1:0]
                     & wake_enable_control; // see [R5]
    assign alt_set = chan_event[WKD_NUM_CHAN-1:WKD_NUM_PINS];
    assign src_clr = (wr_commit && hit_src)
                     ? apb_pwdata_in[WKD_NUM_PINS-1:0] : '0;
    assign alt_clr = (wr_commit && hit_alt_src)
                     ? apb_pwdata_in[WKD_NUM_ALT-1:0] : '0;
    // Set beats a clear that lands in the same cycle
    assign next_src = (wake_source_status & ~src_clr) | src_set; // see [R6]
    assign next_alt = (alt_wake_source_status & ~alt_clr) | alt_set; // see [R8]
    assign next_status = {next_alt, next_src};
    assign any_wake_event = |{alt_set, src_set};

    // ------------------------------------------------------------
    // Pull sources
    // ------------------------------------------------------------
    logic [WKD_NUM_PINS-1:0] next_pu;
    logic [WKD_NUM_PINS-1:0] next_pd;

    generate
        for (g = 0; g < WKD_NUM_PINS; g++)
        begin : g_pull
            wkd_pull_t sel;
            assign sel = wkd_pull_t'(wake_pull_control[2*g +: 2]);
            assign next_pu[g] = sel == WKD_PULL_UP
                || (sel == WKD_PULL_AUTO && chan_level[g]); // see [R9] [R10]
            assign next_pd[g] = sel == WKD_PULL_DOWN
                || (sel == WKD_PULL_AUTO && !chan_level[g]); // see [R9] [R10]
        end
    endgenerate

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // Levels are hidden outside normal/stop
    assign next_rdata =
        hit_enable ? 32'(wake_enable_control) :
        hit_pull ? 32'(wake_pull_control) :
        hit_filter ? 32'(wake_filter_control) :
        hit_src ? 32'(wake_source_status) :
        hit_alt_src ? 32'(alt_wake_source_status) :
        hit_level ? 32'(irq_mode ? chan_level[WKD_NUM_PINS-1:0]
                                 : 3'h0) : // see [R7]
        hit_mask ? 32'(irq_mask) :
        hit_alt_en ? 32'(alt_wake_enable) :
        32'h0000_0000;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            apb_pready_out <= 1'b0;
            apb_prdata_out <= 32'h0000_0000;
            apb_pslverr_out <= 1'b0;
        end
        else
        begin
            // No wait state: ready and read data are registered in the setup cycle
            apb_pready_out <= setup_phase;
            if (setup_phase)
            begin
                apb_prdata_out <= req.write ? 32'h0000_0000 : next_rdata;
                apb_pslverr_out <= !hit_any;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wake_enable_control <= WKD_RST_ENABLE;
            wake_pull_control <= WKD_RST_PULL;
            wake_filter_control <= WKD_RST_FILTER;
            irq_mask <= WKD_RST_MASK;
            alt_wake_enable <= WKD_RST_ALT_EN;
        end
        else if (wr_commit)
        begin
            if (hit_enable)
                wake_enable_control <= apb_pwdata_in[2:0]; // see [R5]
            if (hit_pull)
                wake_pull_control <= apb_pwdata_in[5:0]; // see [R9]
            if (hit_filter)
                wake_filter_control <= apb_pwdata_in[5:0]; // see [R11]
            if (hit_mask)
                irq_mask <= apb_pwdata_in[4:0];
            if (hit_alt_en)
                alt_wake_enable <= apb_pwdata_in[1:0];
        end
    end

    // ------------------------------------------------------------
    // Status, pulls and outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wake_source_status <= '0;
            alt_wake_source_status <= '0;
            pull_up_out <= '0;
            pull_down_out <= '0;
            irq_out <= 1'b0;
            wake_request_out <= 1'b0;
        end
        else
        begin
            wake_source_status <= next_src;
            alt_wake_source_status <= next_alt;
            pull_up_out <= next_pu;
            pull_down_out <= next_pd;
            irq_out <= irq_mode && |(next_status & ~irq_mask); // see [R2]
            wake_request_out <= !irq_mode && any_wake_event; // see [R2]
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    a_both_edges: assert property ( // see [R1]
        chan_event[0] && wake_enable_control[0] |=> wake_source_status[0])
        else $error("Pin one edge not recorded");
    a_irq_in_run: assert property ( // see [R2]
        irq_mode && $stable(power_mode_in) && |(next_status & ~irq_mask)
        |=> irq_out)
        else $error("Interrupt missing in normal or stop mode");
    a_wake_in_sleep: assert property ( // see [R2]
        !irq_mode && src_set != '0 |=> wake_request_out && !irq_out)
        else $error("Wake request missing in sleep or fail-safe");
    a_cyclic_gate: assert property ( // see [R3]
        wake_filter_control[1:0] == WKD_FLT_CYCLIC_A
        && !cyclic_timer_a_window_in |=> !chan_event[0])
        else $error("Cyclic pin accepted edge outside window");
    a_enable_gate: assert property ( // see [R5]
        !wake_enable_control[1] && !wake_source_status[1]
        && !(wr_commit && hit_enable) |=> !wake_source_status[1])
        else $error("Disabled pin set its wake source bit");
    a_source_sticky: assert property ( // see [R6]
        wake_source_status[2] && !src_clr[2] |=> wake_source_status[2])
        else $error("Wake source bit lost without a clear");
    a_level_read: assert property ( // see [R7]
        setup_phase && !req.write && hit_level && !irq_mode
        |=> apb_prdata_out == 32'h0000_0000)
        else $error("Level read outside normal or stop mode");
    a_alt_status: assert property ( // see [R8]
        alt_set[1] && src_set == '0 && src_clr == '0
        |=> alt_wake_source_status[1] && $stable(wake_source_status))
        else $error("Fail-output wake landed in the wrong register");
    a_pull_auto: assert property ( // see [R10]
        wake_pull_control[5:4] == WKD_PULL_AUTO && $stable(wake_pull_control)
        |=> pull_up_out[2] == $past(chan_level[2])
            && pull_down_out[2] != $past(chan_level[2]))
        else $error("Automatic pull does not follow the level");
    a_pull_none: assert property ( // see [R9]
        wake_pull_control[5:4] == WKD_PULL_NONE
        |=> !pull_up_out[2] && !pull_down_out[2])
        else $error("Pull source active with no source selected");
    a_apb_answer: assert property (
        setup_phase |=> apb_pready_out ##1 !apb_pready_out)
        else $error("Bus answer not one cycle after setup");

    c_wake_irq: cover property (irq_mode && src_set != '0 ##1 irq_out);
    c_wake_sleep: cover property (wake_request_out);
    c_alt_event: cover property (alt_set != '0);
    c_clear_race: cover property (|(src_set & src_clr));

endmodule // wkd_wake_input

// ==== tb/wkd_pin_driver.sv ====
`timescale 1ns/100ps
module wkd_pin_driver
    import wkd_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic [WKD_NUM_PINS-1:0] drive_en_in,
    input wire logic [WKD_NUM_PINS-1:0] drive_val_in,
    input wire logic [WKD_NUM_PINS-1:0] pull_up_in,
    input wire logic [WKD_NUM_PINS-1:0] pull_down_in,
    output logic [WKD_NUM_PINS-1:0] pin_out
);
    initial pin_out = '0;

    // Released pin follows the pull source; with none it toggles every
    // cycle, so a floating pin never looks like a settled level
    always @(posedge ref_clk_in)
    begin
        for (int i = 0; i < WKD_NUM_PINS; i++)
        begin
            if (drive_en_in[i])
                pin_out[i] <= drive_val_in[i];
            else if (pull_up_in[i])
                pin_out[i] <= 1'b1;
            else if (pull_down_in[i])
                pin_out[i] <= 1'b0;
            else
                pin_out[i] <= ~pin_out[i];
        end
    end
endmodule // wkd_pin_driver

// ==== tb/wkd_wake_input_test.sv ====
`timescale 1ns/100ps
module wkd_wake_input_test
    import wkd_pkg::*;
;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [2:0] drv_en = 3'h7;
    logic [2:0] drv_val = 3'h0;
    logic [1:0] fo = 2'h0;
    logic win_a = 1'b0;
    logic win_b = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [31:0] rd;
    logic err;
    logic pready, pslverr, irq, wreq;
    logic [31:0] prdata;
    logic [2:0] pin, pu, pd;
    int failures = 0;
    int check_count = 0;

    always #50 ref_clk_in = ~ref_clk_in;

    wkd_pin_driver i_pins(.ref_clk_in(ref_clk_in), .drive_en_in(drv_en),
        .drive_val_in(drv_val), .pull_up_in(pu), .pull_down_in(pd),
        .pin_out(pin));

    wkd_wake_input i_dut(.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .apb_psel_in(psel), .apb_penable_in(penable),
        .apb_pwrite_in(pwrite), .apb_paddr_in(paddr),
        .apb_pwdata_in(pwdata), .apb_pready_out(pready),
        .apb_prdata_out(prdata), .apb_pslverr_out(pslverr),
        .wake_pin_in(pin), .fail_output_pins_in(fo),
        .cyclic_timer_a_window_in(win_a), .cyclic_timer_b_window_in(win_b),
        .power_mode_in(mode), .pull_up_out(pu), .pull_down_out(pd),
        .irq_out(irq), .wake_request_out(wreq));

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Read data and error are taken at the edge that ends the access
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge ref_clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_in);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk_in);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            failures++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic reg_is(input string what, input logic [7:0] a,
        input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask

    task automatic pins(input logic [2:0] v);
        @(posedge ref_clk_in);
        drv_val <= v;
    endtask

    task automatic irq_is(input logic exp);
        wait_cyc(2);
        @(negedge ref_clk_in);
        check("irq", 32'(exp), 32'(irq));
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_reset;
        reg_is("enable", WKD_OFS_ENABLE, 32'h0);
        reg_is("pull", WKD_OFS_PULL, 32'h0);
        reg_is("filter", WKD_OFS_FILTER, 32'h0);
        reg_is("source", WKD_OFS_SRC, 32'h0);
        reg_is("alt source", WKD_OFS_ALT_SRC, 32'h0);
        reg_is("mask", WKD_OFS_MASK, 32'h0);
        reg_is("alt enable", WKD_OFS_ALT_EN, 32'h0);
        check("pull outs", 32'h0, 32'({pu, pd}));
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped error", 32'h1, 32'(err));
        $display("test reset done");
    endtask

    task automatic t_static;
        apb(1'b1, WKD_OFS_ENABLE, 32'h7);
        pins(3'h1);
        wait_cyc(100);
        pins(3'h0);
        wait_cyc(200);
        reg_is("glitch source", WKD_OFS_SRC, 32'h0);
        pins(3'h1);
        wait_cyc(150);
        reg_is("early source", WKD_OFS_SRC, 32'h0);
        wait_cyc(20);
        reg_is("rise source", WKD_OFS_SRC, 32'h1);
        irq_is(1'b1);
        apb(1'b1, WKD_OFS_MASK, 32'h1);
        irq_is(1'b0);
        apb(1'b1, WKD_OFS_MASK, 32'h0);
        irq_is(1'b1);
        apb(1'b1, WKD_OFS_SRC, 32'h1);
        reg_is("cleared source", WKD_OFS_SRC, 32'h0);
        irq_is(1'b0);
        pins(3'h0);
        wait_cyc(170);
        reg_is("fall source", WKD_OFS_SRC, 32'h1);
        apb(1'b1, WKD_OFS_SRC, 32'h7);
        $display("test static done");
    endtask

    task automatic t_enable;
        apb(1'b1, WKD_OFS_ENABLE, 32'h5);
        pins(3'h3);
        wait_cyc(200);
        reg_is("partial source", WKD_OFS_SRC, 32'h1);
        reg_is("level", WKD_OFS_LEVEL, 32'h3);
        apb(1'b1, WKD_OFS_SRC, 32'h7);
        pins(3'h7);
        wait_cyc(200);
        reg_is("pin three source", WKD_OFS_SRC, 32'h4);
        pins(3'h0);
        wait_cyc(200);
        apb(1'b1, WKD_OFS_SRC, 32'h7);
        apb(1'b1, WKD_OFS_ENABLE, 32'h7);
        $display("test enable done");
    endtask

    task automatic t_long;
        apb(1'b1, WKD_OFS_FILTER, 32'h4);
        pins(3'h2);
        wait_cyc(400);
        reg_is("long early", WKD_OFS_SRC, 32'h0);
        wait_cyc(300);
        reg_is("long source", WKD_OFS_SRC, 32'h2);
        pins(3'h0);
        wait_cyc(700);
        apb(1'b1, WKD_OFS_SRC, 32'h7);
        apb(1'b1, WKD_OFS_FILTER, 32'h0);
        $display("test long filter done");
    endtask

    task automatic t_cyclic;
        apb(1'b1, WKD_OFS_FILTER, 32'h32);
        // Pins are driven all along, independent of the sensing windows
        pins(3'h5);
        wait_cyc(300);
        reg_is("closed source", WKD_OFS_SRC, 32'h0);
        reg_is("closed level", WKD_OFS_LEVEL, 32'h0);
        win_a <= 1'b1;
        wait_cyc(200);
        reg_is("timer a source", WKD_OFS_SRC, 32'h1);
        win_a <= 1'b0;
        pins(3'h4);
        win_b <= 1'b1;
        wait_cyc(200);
        reg_is("timer b source", WKD_OFS_SRC, 32'h5);
        reg_is("sampled level", WKD_OFS_LEVEL, 32'h5);
        win_b <= 1'b0;
        apb(1'b1, WKD_OFS_FILTER, 32'h0);
        pins(3'h0);
        wait_cyc(200);
        apb(1'b1, WKD_OFS_SRC, 32'h7);
        $display("test cyclic done");
    endtask

    task automatic t_modes;
        int n;
        for (int m = 1; m < 4; m++)
        begin
            mode <= 2'(m);
            pins(3'(m[0] ? 2 : 0));
            n = 0;
            repeat (300)
            begin
                @(negedge ref_clk_in);
                if (wreq === 1'b1)
                    n++;
            end
            check("wake pulses", 32'(m >= 2), 32'(n));
            check("mode irq", 32'(m < 2), 32'(irq));
            mode <= WKD_MODE_NORMAL;
            apb(1'b1, WKD_OFS_SRC, 32'h7);
        end
        $display("test power modes done");
    endtask

    task automatic t_pull;
        apb(1'b1, WKD_OFS_PULL, 32'h39);
        wait_cyc(3);
        check("pull up", 32'h2, 32'(pu));
        check("pull down", 32'h5, 32'(pd));
        pins(3'h4);
        wait_cyc(200);
        check("auto up", 32'h6, 32'(pu));
        check("auto down", 32'h1, 32'(pd));
        drv_en <= 3'h5;
        wait_cyc(200);
        reg_is("pulled level", WKD_OFS_LEVEL, 32'h6);
        drv_en <= 3'h7;
        pins(3'h0);
        apb(1'b1, WKD_OFS_PULL, 32'h0);
        wait_cyc(200);
        apb(1'b1, WKD_OFS_SRC, 32'h7);
        $display("test pull done");
    endtask

    task automatic t_alt;
        apb(1'b1, WKD_OFS_ALT_EN, 32'h2);
        fo <= 2'h3;
        wait_cyc(200);
        reg_is("alt source", WKD_OFS_ALT_SRC, 32'h2);
        reg_is("main source", WKD_OFS_SRC, 32'h0);
        irq_is(1'b1);
        apb(1'b1, WKD_OFS_ALT_SRC, 32'h2);
        reg_is("alt cleared", WKD_OFS_ALT_SRC, 32'h0);
        irq_is(1'b0);
        $display("test alt done");
    endtask

    initial
    begin
        wait_cyc(3);
        rst_in <= 1'b0;
        t_reset();
        t_static();
        t_enable();
        t_long();
        t_cyclic();
        t_modes();
        t_pull();
        t_alt();
        tally_and_finish();
    end
endmodule // wkd_wake_input_test
